// ==== logic/tx_stats_regs.vh ====
// register offsets, field positions, reset values for the tx stats block
// assumes byte addresses on a 32-bit apb bus, one word per register
`ifndef TX_STATS_REGS_VH
`define TX_STATS_REGS_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define STATS_CONTROL_OFS 12'h100
`define RX_STATS_IRQ_STATUS_OFS 12'h104
`define TX_STATS_IRQ_STATUS_OFS 12'h108
`define RX_STATS_IRQ_MASK_OFS 12'h10c
`define TX_STATS_IRQ_MASK_OFS 12'h110
`define TX_BYTES_ALL_OFS 12'h114
`define TX_FRAMES_ALL_OFS 12'h118
`define TX_BCAST_GOOD_OFS 12'h11c
`define TX_MCAST_GOOD_OFS 12'h120
`define TX_LEN_EXACT_MIN_OFS 12'h124
`define TX_LEN_BIN_65_127_OFS 12'h128
`define TX_LEN_BIN_128_255_OFS 12'h12c
`define TX_LEN_BIN_256_511_OFS 12'h130
`define TX_LEN_BIN_512_1023_OFS 12'h134
`define TX_LEN_BIN_1024_MAX_OFS 12'h138
`define TX_UCAST_ALL_OFS 12'h13c
`define TX_MCAST_ALL_OFS 12'h140

// ****************************************************************
// counter indices (offset = TX_BYTES_ALL_OFS + 4 * index)
// ****************************************************************
`define CNT_NUM 12
`define CNT_BYTES 0
`define CNT_FRAMES 1
`define CNT_BCAST_G 2
`define CNT_MCAST_G 3
`define CNT_LEN_64 4
`define CNT_LEN_127 5
`define CNT_LEN_255 6
`define CNT_LEN_511 7
`define CNT_LEN_1023 8
`define CNT_LEN_MAX 9
`define CNT_UCAST 10
`define CNT_MCAST 11

// ****************************************************************
// stats_control fields
// ****************************************************************
`define CTL_CNT_RESET 0
`define CTL_NO_ROLLOVER 1
`define CTL_RESET_ON_READ 2
`define CTL_FREEZE 3
`define CTL_MAXLEN_LSB 16
`define CTL_MAXLEN_MSB 29
`define CTL_RESET 32'h05ee_0000

// ****************************************************************
// length bin bounds
// ****************************************************************
`define LEN_MIN 14'h0040
`define LEN_127 14'h007f
`define LEN_255 14'h00ff
`define LEN_511 14'h01ff
`define LEN_1023 14'h03ff

`endif

// ==== logic/tx_stats.v ====
// transmit statistics counters with control, irq status and mask regs
// assumes frame events come from mac tx logic on clk, one pulse per attempt
//
// Design decision made here: the APB register port.
`include "tx_stats_regs.vh"

module tx_stats (
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata_ff,
  input wire tx_frame_done,
  input wire tx_frame_ok,
  input wire tx_frame_retry,
  input wire [13:0] tx_frame_len,
  input wire tx_dest_bcast,
  input wire tx_dest_mcast,
  input wire [31:0] rx_stats_event,
  output wire stats_irq
);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire setup;
  wire access;
  wire wr_acc;
  wire rd_acc;
  wire hit_ctl;
  wire hit_rxst;
  wire hit_txst;
  wire hit_rxmk;
  wire hit_txmk;
  wire hit_cnt;
  wire mapped;
  wire [11:0] cnt_ofs;
  wire [3:0] cnt_idx;

  assign setup = psel & ~penable;
  assign access = psel & penable & clk_en;
  assign wr_acc = access & pwrite;
  assign rd_acc = access & ~pwrite;
  assign hit_ctl = paddr == `STATS_CONTROL_OFS;
  assign hit_rxst = paddr == `RX_STATS_IRQ_STATUS_OFS;
  assign hit_txst = paddr == `TX_STATS_IRQ_STATUS_OFS;
  assign hit_rxmk = paddr == `RX_STATS_IRQ_MASK_OFS;
  assign hit_txmk = paddr == `TX_STATS_IRQ_MASK_OFS;
  assign cnt_ofs = paddr - `TX_BYTES_ALL_OFS;
  assign cnt_idx = cnt_ofs[5:2];
  assign hit_cnt = (paddr >= `TX_BYTES_ALL_OFS) &&
    (paddr <= `TX_MCAST_ALL_OFS) && (paddr[1:0] == 2'b00);
  assign mapped = hit_ctl | hit_rxst | hit_txst | hit_rxmk |
    hit_txmk | hit_cnt;

  // zero wait states; the only stall is a low clock enable
  assign pready = penable & clk_en;
  assign pslverr = psel & penable & ~mapped;

  // ****************************************************************
  // control and mask registers
  // ****************************************************************
  reg [31:0] ctl_ff;
  reg [31:0] rx_mask_ff;
  reg [31:0] tx_mask_ff;
  wire [31:0] ctl_rd;
  wire [13:0] max_len;
  wire cnt_clear;
  wire no_roll;
  wire rd_clear;
  wire freeze;

  // self-clearing counter reset bit never reads back as one
  assign ctl_rd = {ctl_ff[31:1], 1'b0};
  assign max_len = ctl_ff[`CTL_MAXLEN_MSB:`CTL_MAXLEN_LSB];
  assign cnt_clear = ctl_ff[`CTL_CNT_RESET];
  assign no_roll = ctl_ff[`CTL_NO_ROLLOVER];
  assign rd_clear = ctl_ff[`CTL_RESET_ON_READ];
  assign freeze = ctl_ff[`CTL_FREEZE];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff <= `CTL_RESET;
      rx_mask_ff <= 32'h0000_0000;
      tx_mask_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      if (wr_acc && hit_ctl) begin
        ctl_ff <= pwdata;
      end else begin
        ctl_ff[`CTL_CNT_RESET] <= 1'b0;
      end
      if (wr_acc && hit_rxmk) begin
        rx_mask_ff <= pwdata;
      end
      if (wr_acc && hit_txmk) begin
        tx_mask_ff <= pwdata;
      end
    end
  end

  // ****************************************************************
  // frame classification
  // ****************************************************************
  wire frame_ev;
  wire good_ev;
  wire ucast;
  wire [`CNT_NUM-1:0] inc;

  // a retried attempt is dropped whole; its final attempt counts
  assign frame_ev = tx_frame_done & ~tx_frame_retry & ~freeze;
  assign good_ev = frame_ev & tx_frame_ok;
  assign ucast = ~tx_dest_bcast & ~tx_dest_mcast;

  assign inc[`CNT_BYTES] = frame_ev;
  assign inc[`CNT_FRAMES] = frame_ev;
  assign inc[`CNT_BCAST_G] = good_ev & tx_dest_bcast;
  assign inc[`CNT_MCAST_G] = good_ev & tx_dest_mcast;
  // bins are disjoint so a frame lands in at most one
  assign inc[`CNT_LEN_64] = frame_ev &
    (tx_frame_len == `LEN_MIN);
  assign inc[`CNT_LEN_127] = frame_ev &
    (tx_frame_len > `LEN_MIN) & (tx_frame_len <= `LEN_127);
  assign inc[`CNT_LEN_255] = frame_ev &
    (tx_frame_len > `LEN_127) & (tx_frame_len <= `LEN_255);
  assign inc[`CNT_LEN_511] = frame_ev &
    (tx_frame_len > `LEN_255) & (tx_frame_len <= `LEN_511);
  assign inc[`CNT_LEN_1023] = frame_ev &
    (tx_frame_len > `LEN_511) & (tx_frame_len <= `LEN_1023);
  // frames above both 1023 and max_len fall in no bin; only this top bin checks max_len
  assign inc[`CNT_LEN_MAX] = frame_ev &
    (tx_frame_len > `LEN_1023) & (tx_frame_len <= max_len);
  assign inc[`CNT_UCAST] = frame_ev & ucast;
  assign inc[`CNT_MCAST] = frame_ev & tx_dest_mcast;

  // ****************************************************************
  // counters
  // ****************************************************************
  reg [31:0] cnt_ff [0:`CNT_NUM-1];
  wire [`CNT_NUM-1:0] half_hit;
  wire [31:0] tx_ev;

  genvar gi;
  generate
    for (gi = 0; gi < `CNT_NUM; gi = gi + 1) begin : g_cnt
      wire [31:0] step;
      wire [32:0] sum;
      wire [31:0] base;
      wire [31:0] nxt_cnt;
      wire rd_me;

      assign step = (gi == `CNT_BYTES) ? {18'h0, tx_frame_len} :
        32'h0000_0001;
      assign rd_me = rd_acc && hit_cnt && (cnt_idx == gi);
      // read-clear happens first so an event in that cycle survives
      assign base = (rd_me && rd_clear) ? 32'h0000_0000 :
        cnt_ff[gi];
      assign sum = {1'b0, base} + {1'b0, step};
      assign nxt_cnt = !inc[gi] ? base :
        (sum[32] && no_roll) ? 32'hffff_ffff : sum[31:0];
      // irq when the counter crosses half range or reaches full
      assign half_hit[gi] = inc[gi] &&
        ((nxt_cnt[31] && !cnt_ff[gi][31]) ||
        (nxt_cnt == 32'hffff_ffff && cnt_ff[gi] != 32'hffff_ffff));

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_ff[gi] <= 32'h0000_0000;
        end else if (clk_en) begin
          if (cnt_clear) begin
            cnt_ff[gi] <= 32'h0000_0000;
          end else begin
            cnt_ff[gi] <= nxt_cnt;
          end
        end
      end
    end
  endgenerate

  assign tx_ev = {{(32 - `CNT_NUM){1'b0}}, half_hit};

  // ****************************************************************
  // interrupt status
  // ****************************************************************
  reg [31:0] rx_st_ff;
  reg [31:0] tx_st_ff;
  wire rd_rxst;
  wire rd_txst;

  assign rd_rxst = rd_acc & hit_rxst;
  assign rd_txst = rd_acc & hit_txst;

  // status clears on read; a new event in that cycle still sets
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_ff <= 32'h0000_0000;
      tx_st_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      rx_st_ff <= (rd_rxst ? 32'h0000_0000 : rx_st_ff) |
        rx_stats_event;
      tx_st_ff <= (rd_txst ? 32'h0000_0000 : tx_st_ff) |
        tx_ev;
    end
  end

  // a set mask bit suppresses that source
  assign stats_irq = |(rx_st_ff & ~rx_mask_ff) |
    |(tx_st_ff & ~tx_mask_ff);

  // ****************************************************************
  // read data
  // ****************************************************************
  reg [31:0] nxt_rdata;

  always @* begin
    nxt_rdata = 32'h0000_0000;
    if (hit_ctl) begin
      nxt_rdata = ctl_rd;
    end else if (hit_rxst) begin
      nxt_rdata = rx_st_ff;
    end else if (hit_txst) begin
      nxt_rdata = tx_st_ff;
    end else if (hit_rxmk) begin
      nxt_rdata = rx_mask_ff;
    end else if (hit_txmk) begin
      nxt_rdata = tx_mask_ff;
    end else if (hit_cnt) begin
      nxt_rdata = cnt_ff[cnt_idx];
    end
  end

  // captured in setup; counter may move before access, the
  // setup-cycle value is what is returned, the access-cycle value is what is cleared-on-read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (clk_en && setup && !pwrite) begin
      prdata_ff <= nxt_rdata;
    end
  end

endmodule

// ==== sim/tx_stats_sva.sv ====
// port-level checks for the tx statistics block
// assumes one clock, rst_n asynchronous active low
module tx_stats_sva (
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata_ff,
  input wire tx_frame_done,
  input wire tx_frame_ok,
  input wire tx_frame_retry,
  input wire [13:0] tx_frame_len,
  input wire tx_dest_bcast,
  input wire tx_dest_mcast,
  input wire [31:0] rx_stats_event,
  input wire stats_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire unm = paddr < 12'h100 || paddr > 12'h140;
  wire rd_setup = psel && !penable && !pwrite && clk_en;
  property p_rdy; pready == (penable && clk_en); endproperty
  a_rdy: assert property (p_rdy) else $error("pready wrong");
  property p_err; acc && paddr[1:0] == 2'h0 |-> pslverr == unm; endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  property p_err_idle; !acc |-> !pslverr; endproperty
  a_err_idle: assert property (p_err_idle) else $error("stray err");
  property p_hold; !rd_setup |=> $stable(prdata_ff); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_unm_rd; rd_setup && paddr == 12'h144 |=> prdata_ff == 0; endproperty
  a_unm_rd: assert property (p_unm_rd) else $error("hole data");
  property p_frz; !clk_en |=> $stable(stats_irq); endproperty
  a_frz: assert property (p_frz) else $error("irq moved frozen");
  property p_irq_up;
    $rose(stats_irq) |->
      $past(tx_frame_done || (|rx_stats_event) || (acc && pwrite));
  endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq no cause");
  property p_irq_dn; $fell(stats_irq) |-> $past(acc); endproperty
  a_irq_dn: assert property (p_irq_dn) else $error("irq drop");
  c_frame: cover property (tx_frame_done && !tx_frame_retry);
  c_irq: cover property ($rose(stats_irq));
  c_err: cover property (pslverr);
endmodule

bind tx_stats tx_stats_sva u_sva (.clk, .rst_n, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata_ff, .tx_frame_done,
  .tx_frame_ok, .tx_frame_retry, .tx_frame_len, .tx_dest_bcast,
  .tx_dest_mcast, .rx_stats_event, .stats_irq);

// ==== sim/mac_tx_model.sv ====
// mac transmit path model: one done pulse per finished attempt
// assumes caller steps it from a single process on clk
module mac_tx_model (
  input wire clk,
  output logic tx_frame_done,
  output logic tx_frame_ok,
  output logic tx_frame_retry,
  output logic [13:0] tx_frame_len,
  output logic tx_dest_bcast,
  output logic tx_dest_mcast
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tx_frame_done = 1'b0;
    tx_frame_len = 14'h0;
    {tx_frame_ok, tx_frame_retry, tx_dest_bcast, tx_dest_mcast} = 4'h0;
  end
  // f is {ok, retry, bcast, mcast}; calls may follow back to back
  task automatic send(input logic [13:0] len, input logic [3:0] f);
    @(posedge clk);
    tx_frame_done <= 1'b1;
    tx_frame_len <= len;
    {tx_frame_ok, tx_frame_retry, tx_dest_bcast, tx_dest_mcast} <= f;
  endtask
  // qualifiers mean nothing without done, so scramble len, retry and mcast
  task automatic quiet();
    @(posedge clk);
    tx_frame_done <= 1'b0;
    tx_frame_len <= ~tx_frame_len;
    tx_frame_retry <= ~tx_frame_retry;
    tx_dest_mcast <= ~tx_dest_mcast;
  endtask
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the tx statistics block
// assumes mac_tx_model drives the frame side, apb driven here
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rx_stats_event = 0, rd;
  logic er;
  wire pready, pslverr, stats_irq, tx_frame_done, tx_frame_ok;
  wire tx_frame_retry, tx_dest_bcast, tx_dest_mcast;
  wire [31:0] prdata_ff;
  wire [13:0] tx_frame_len;
  int err_total = 0, n_checks = 0;
  always #2 clk = ~clk;
  mac_tx_model u_mac (.clk, .tx_frame_done, .tx_frame_ok, .tx_frame_retry,
    .tx_frame_len, .tx_dest_bcast, .tx_dest_mcast);
  tx_stats u_dut (.clk, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata_ff, .tx_frame_done, .tx_frame_ok,
    .tx_frame_retry, .tx_frame_len, .tx_dest_bcast, .tx_dest_mcast,
    .rx_stats_event, .stats_irq);
  // ********
  // bus and compare helpers
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata_ff;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input int i, input logic [31:0] e);
    apb(0, 12'h114 + 12'(4 * i), 0);
    chk(rd, e);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset();
    apb(0, 12'h100, 0);
    chk(rd, 32'h05ee_0000);
    apb(0, 12'h104, 0);
    chk(rd, 0);
    apb(0, 12'h108, 0);
    chk(rd, 0);
    chk(stats_irq, 0);
  endtask
  // every bin edge, one oversize and one retry, all back to back
  task automatic t_frames();
    u_mac.send(64, 4'b1010);
    u_mac.send(65, 4'b1001);
    u_mac.send(127, 4'b0001);
    u_mac.send(128, 4'b1000);
    u_mac.send(255, 4'b0000);
    u_mac.send(100, 4'b1101);
    u_mac.send(256, 4'b1000);
    u_mac.send(511, 4'b1000);
    u_mac.send(512, 4'b1000);
    u_mac.send(1023, 4'b1000);
    u_mac.send(1024, 4'b1000);
    u_mac.send(1518, 4'b0010);
    u_mac.send(1519, 4'b1000);
    u_mac.quiet();
    rdc(0, 7002);
    rdc(1, 12);
    rdc(2, 1);
    rdc(3, 1);
    rdc(4, 1);
    rdc(5, 2);
    rdc(6, 2);
    rdc(7, 2);
    rdc(8, 2);
    rdc(9, 2);
    rdc(10, 8);
    rdc(11, 2);
  endtask
  task automatic t_bus();
    apb(0, 12'h144, 0);
    chk(rd, 0);
    chk(er, 1);
    apb(1, 12'h118, 32'h55);
    rdc(1, 12);
    chk(er, 0);
  endtask
  task automatic t_irq();
    apb(1, 12'h10c, 32'hffff_ffff);
    apb(0, 12'h10c, 0);
    chk(rd, 32'hffff_ffff);
    @(posedge clk) rx_stats_event <= 32'h8;
    @(posedge clk) rx_stats_event <= 0;
    repeat (2) @(posedge clk);
    chk(stats_irq, 0);
    apb(1, 12'h10c, 0);
    @(posedge clk);
    chk(stats_irq, 1);
    apb(0, 12'h104, 0);
    chk(rd, 32'h8);
    @(posedge clk);
    chk(stats_irq, 0);
    apb(1, 12'h110, 32'h155);
    apb(0, 12'h110, 0);
    chk(rd, 32'h155);
    apb(0, 12'h108, 0);
    chk(rd, 0);
  endtask
  task automatic t_ctrl();
    apb(1, 12'h100, 32'h05ee_0008);
    u_mac.send(64, 4'b1000);
    u_mac.quiet();
    rdc(1, 12);
    @(posedge clk) clk_en <= 1'b0;
    repeat (3) @(posedge clk);
    clk_en <= 1'b1;
    apb(1, 12'h100, 32'h05ee_0004);
    rdc(1, 12);
    rdc(1, 0);
    apb(1, 12'h100, 32'h05ee_0001);
    rdc(0, 0);
    apb(0, 12'h100, 0);
    chk(rd, 32'h05ee_0000);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_frames();
    t_bus();
    t_irq();
    t_ctrl();
    tally_and_finish();
  end
  // run needs well under 1000 cycles
  initial begin
    #40000;
    err_total++;
    tally_and_finish();
  end
endmodule
